// *** core/smspi_pkg.sv ***
// Shared constants and types for the serial memory SPI slave.
package smspi_pkg;

	// Array geometry: 32K bytes of eight bits.
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 32768;

	// Timing: core clock and the fastest serial clock the master may use.
	localparam int CLK_MHZ = 100;
	localparam int SCK_MAX_MHZ = 40;
	// Least core cycles in one serial clock half period that this oversampling front end resolves.
	localparam int SCK_MIN_HALF_CYC = 8;

	// Command codes.
	localparam logic [7:0] OP_WREN = 8'h11;
	localparam logic [7:0] OP_WRDI = 8'h12;
	localparam logic [7:0] OP_RDSR = 8'h13;
	localparam logic [7:0] OP_WRSR = 8'h14;
	localparam logic [7:0] OP_READ = 8'h15;
	localparam logic [7:0] OP_WRITE = 8'h16;
	localparam logic [7:0] OP_RDID = 8'h17;

	// Status byte layout and reset value.
	localparam int SR_PPE_BIT = 7;
	localparam int SR_BP_HI = 3;
	localparam int SR_BP_LO = 2;
	localparam int SR_WEL_BIT = 1;
	localparam logic [7:0] SR_RESET = 8'h00;

	// Block protection settings and the first protected address of the quarter and half settings.
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QUARTER = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [1:0] BP_ALL = 2'h3;
	localparam logic [14:0] QUARTER_BASE = 15'h6000;
	localparam logic [14:0] HALF_BASE = 15'h4000;

	// Index of the last byte of the identification sequence.
	localparam logic [1:0] ID_LAST = 2'h2;

	// Command sequencer states.
	typedef enum logic [2:0] {
		ST_OP = 3'h0,
		ST_ADDH = 3'h1,
		ST_ADDL = 3'h2,
		ST_WRITE = 3'h3,
		ST_READ = 3'h4,
		ST_WRSR = 3'h5,
		ST_RDSR = 3'h6,
		ST_RDID = 3'h7
	} smspi_state_t;

endpackage

// *** core/smspi_mem_if.sv ***
// Port bundle between the command sequencer and the byte array.
`timescale 1ns/1ps
interface smspi_mem_if #(
	parameter int AW = 15,
	parameter int DW = 8
);
	logic wr;
	logic rd;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl (output wr, output rd, output addr, output wdata, input rdata);
	modport mem (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// *** core/smspi_mem.sv ***
// Byte array with one write port and a registered read port.
`timescale 1ns/1ps
module smspi_mem
	import smspi_pkg::*;
#(
	parameter int DEPTH = MEM_DEPTH
) (
	input wire logic clk, // Core clock.
	input wire logic nrst, // Synchronous reset, active low.
	smspi_mem_if.mem m // Access port.
);
	logic [DATA_W-1:0] cells [DEPTH];

	// The array itself is not reset, as a nonvolatile store keeps its contents.
	always_ff @(posedge clk) begin
		if (m.wr) begin
			cells[m.addr] <= m.wdata;
		end
	end

	// Read data come from a register one cycle after the strobe.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			m.rdata <= 8'h00;
		end else if (m.rd) begin
			m.rdata <= cells[m.addr];
		end
	end
endmodule

// *** core/smspi_fifo2.sv ***
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module smspi_fifo2 #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // Core clock.
	input wire logic nrst, // Synchronous reset, active low.
	input wire logic flush, // Empties the buffer.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] in_data, // Offered word.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Drain side takes the word.
	output logic [WIDTH-1:0] out_data // Oldest word.
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] ent;
		logic [1:0] cnt;
	} smspi_fifo_t;

	smspi_fifo_t st;
	smspi_fifo_t next_st;

	assign in_ready = (st.cnt != 2'h2);
	assign out_valid = (st.cnt != 2'h0);
	assign out_data = st.ent[0];

	// Pop shifts the second entry forward; a push in the same cycle only happens with one word held and lands in entry 0.
	always_comb begin
		logic pop;
		logic psh;
		logic [1:0] c;
		pop = 1'b0;
		psh = 1'b0;
		c = 2'h0;
		next_st = st;
		pop = out_valid & out_ready;
		psh = in_valid & in_ready;
		c = st.cnt;
		if (pop) begin
			next_st.ent[0] = st.ent[1];
			c = c - 2'h1;
		end
		if (psh) begin
			next_st.ent[c[0]] = in_data;
			c = c + 2'h1;
		end
		next_st.cnt = flush ? 2'h0 : c;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// *** core/smspi_slave.sv ***
// SPI slave front end of a 32K x 8 serial memory, oversampled on the core clock.
//
// Contract
// RULE1: sample input on rise, change output on fall.
// RULE2: clock any rate, may stop; state kept. Code resolves only half periods of SCK_MIN_HALF_CYC core cycles or more.
// RULE3: deselected: standby, inputs ignored, output released.
// RULE4: master starts every opcode with new select.
// RULE5: serial clock acts only while selected.
// RULE6: serial input looked at only on rises.
// RULE7: output driven only for read data, never paused.
// RULE8: pin low and enable set block status writes.
// RULE9: pause freezes operation, ignores clock and select.
// RULE10: master changes pause only while clock low.
// RULE11: each data byte written at its eighth bit.
// RULE12: works in SPI mode 0 and 3.
// RULE13: 32K byte-addressable locations of eight bits.
// RULE14: block protect quarter, half or whole array.
// RULE15: write-disable command clears write permission.
// RULE16: read-only maker, density, revision identification.
// RULE17: first byte is opcode, then MSB-first bytes.
// RULE18: two address bytes, top bit ignored.
// RULE19: unknown opcode discards rest of selection.
// RULE20: clock level at select picks the mode.
// RULE21: deselect drops partial byte, sequencer to idle.
`timescale 1ns/1ps
module smspi_slave
	import smspi_pkg::*;
#(
	parameter logic [7:0] ID_MAKER = 8'h5C, // Arbitrary value.
	parameter logic [7:0] ID_DENSITY = 8'h21, // Arbitrary value.
	parameter logic [7:0] ID_REV = 8'h01 // Arbitrary value.
) (
	input wire logic CLK, // Core clock, 100 MHz.
	input wire logic NRST, // Synchronous reset, active low.
	input wire logic SCK, // Serial clock pin from the master.
	input wire logic SEL_N, // Select pin, active low.
	input wire logic SI, // Serial data in.
	input wire logic PAUSE_N, // Pause pin, active low.
	input wire logic WP_N, // Status write protect pin, active low.
	output logic SO, // Serial data out.
	output logic SO_OE // High while SO is driven.
);
	typedef struct packed {
		logic sck_m;
		logic sck_s;
		logic sck_d;
		logic sel_m;
		logic sel_s;
		logic si_m;
		logic si_s;
		logic pau_m;
		logic pau_s;
		logic wp_m;
		logic wp_s;
		logic act;
		logic mode3;
		logic seen;
		logic [2:0] bitc;
		logic [7:0] rx;
		logic push;
		logic [7:0] push_data;
		smspi_state_t state;
		logic is_read;
		logic [14:0] addr;
		logic ppe;
		logic wel;
		logic [1:0] bp;
		logic [7:0] txn;
		logic txv;
		logic need;
		logic [7:0] txsh;
		logic so;
		logic oe;
		logic fetch;
		logic [1:0] id_idx;
		logic wr;
		logic rd;
		logic [14:0] maddr;
		logic [7:0] wdata;
	} smspi_core_t;

	localparam smspi_core_t CORE_RESET = '{
		sck_m: 1'b0, sck_s: 1'b0, sck_d: 1'b0, sel_m: 1'b1, sel_s: 1'b1,
		si_m: 1'b0, si_s: 1'b0, pau_m: 1'b1, pau_s: 1'b1, wp_m: 1'b1, wp_s: 1'b1,
		act: 1'b0, mode3: 1'b0, seen: 1'b0, bitc: 3'h0, rx: 8'h00,
		push: 1'b0, push_data: 8'h00, state: ST_OP, is_read: 1'b0, addr: 15'h0000,
		ppe: SR_RESET[SR_PPE_BIT], wel: SR_RESET[SR_WEL_BIT], bp: SR_RESET[SR_BP_HI:SR_BP_LO],
		txn: 8'h00, txv: 1'b0, need: 1'b0, txsh: 8'h00, so: 1'b0, oe: 1'b0,
		fetch: 1'b0, id_idx: 2'h0, wr: 1'b0, rd: 1'b0, maddr: 15'h0000, wdata: 8'h00
	};

	smspi_core_t st;
	smspi_core_t next_st;
	logic pop_valid;
	logic pop_ready;
	logic [7:0] pop_data;
	logic push_ready;

	smspi_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mif ();

	// True when a byte address falls in the region that the protection setting locks.
	function automatic logic blocked(input logic [14:0] a, input logic [1:0] bp);
		case (bp)
			BP_QUARTER: blocked = (a >= QUARTER_BASE);
			BP_HALF: blocked = (a >= HALF_BASE);
			BP_ALL: blocked = 1'b1;
			default: blocked = 1'b0;
		endcase
	endfunction

	// Assembles the status byte from its fields; unused bits read as zero.
	function automatic logic [7:0] status_byte(input logic ppe, input logic [1:0] bp, input logic wel);
		logic [7:0] s;
		s = 8'h00;
		s[SR_PPE_BIT] = ppe;
		s[SR_BP_HI:SR_BP_LO] = bp;
		s[SR_WEL_BIT] = wel;
		status_byte = s;
	endfunction

	// Identification bytes in the order maker, density, revision.
	function automatic logic [7:0] id_byte(input logic [1:0] i);
		case (i)
			2'h0: id_byte = ID_MAKER;
			2'h1: id_byte = ID_DENSITY;
			default: id_byte = ID_REV;
		endcase
	endfunction

	// Received bytes wait here so a one-cycle array fetch never loses a byte.
	smspi_fifo2 #(.WIDTH(DATA_W)) rx_buf (
		.clk(CLK),
		.nrst(NRST),
		.flush(~st.act),
		.in_valid(st.push),
		.in_ready(push_ready),
		.in_data(st.push_data),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_data)
	);

	smspi_mem #(.DEPTH(MEM_DEPTH)) array (
		.clk(CLK),
		.nrst(NRST),
		.m(mif.mem)
	);

	// The sequencer stalls the buffer while a fetch is in flight.
	assign pop_ready = st.act & ~st.rd & ~st.fetch;
	assign mif.wr = st.wr;
	assign mif.rd = st.rd;
	assign mif.addr = st.maddr;
	assign mif.wdata = st.wdata;
	assign SO = st.so;
	// Released when deselected and at once when the master pauses.
	assign SO_OE = st.oe & st.act & st.pau_s; // RULE7 RULE3 RULE9

	// Pin front end and command sequencer.
	always_comb begin
		logic paused;
		logic rise;
		logic fall;
		logic take;
		logic [7:0] b;
		paused = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		take = 1'b0;
		b = 8'h00;
		next_st = st;
		next_st.wr = 1'b0;
		next_st.rd = 1'b0;
		// Array data are registered, so they are only valid one cycle after the read strobe.
		next_st.fetch = st.rd;
		next_st.push = 1'b0;
		next_st.need = 1'b0;

		// Every pin passes two flops and SCK a third; the first stage is never read.
		next_st.sck_m = SCK;
		next_st.sck_s = st.sck_m;
		next_st.sck_d = st.sck_s;
		next_st.sel_m = SEL_N;
		next_st.sel_s = st.sel_m;
		next_st.si_m = SI;
		next_st.si_s = st.si_m;
		next_st.pau_m = PAUSE_N;
		next_st.pau_s = st.pau_m;
		next_st.wp_m = WP_N;
		next_st.wp_s = st.wp_m;

		// Edges seen during a pause are dropped, since the delayed copy keeps tracking the pin.
		paused = ~st.pau_s; // RULE9
		rise = st.sck_s & ~st.sck_d & st.act & ~paused; // RULE5 RULE2
		fall = ~st.sck_s & st.sck_d & st.act & ~paused; // RULE5
		take = pop_valid & pop_ready;
		b = pop_data;

		if (!paused && st.sel_s && st.act) begin
			// Deselect drops any partial byte and returns to standby.
			next_st.act = 1'b0; // RULE3 RULE21
			next_st.state = ST_OP; // RULE21
			next_st.bitc = 3'h0; // RULE21
			next_st.oe = 1'b0;
			next_st.txv = 1'b0;
		end else if (!paused && !st.sel_s && !st.act) begin
			// A new selection latches the mode from the clock level.
			next_st.act = 1'b1;
			next_st.mode3 = st.sck_s; // RULE20 RULE12
			next_st.seen = 1'b0;
			next_st.bitc = 3'h0;
			next_st.state = ST_OP; // RULE17
			next_st.oe = 1'b0;
			next_st.txv = 1'b0;
		end else begin
			// Input is sampled only on rises, most significant bit first.
			if (rise) begin
				next_st.seen = 1'b1;
				next_st.rx = {st.rx[6:0], st.si_s}; // RULE1 RULE6 RULE17
				next_st.bitc = st.bitc + 3'h1;
				if (st.bitc == 3'h7) begin
					next_st.push = push_ready;
					next_st.push_data = {st.rx[6:0], st.si_s};
				end
			end
			// In mode 3 the fall that precedes the first rise carries no data.
			if (fall && (st.seen || !st.mode3)) begin // RULE12
				if (st.bitc == 3'h0) begin
					next_st.oe = st.txv; // RULE7
					next_st.so = st.txn[7]; // RULE1
					next_st.txsh = {st.txn[6:0], 1'b0};
					next_st.txv = 1'b0;
					next_st.need = st.txv;
				end else begin
					next_st.so = st.txsh[7]; // RULE1
					next_st.txsh = {st.txsh[6:0], 1'b0};
				end
			end

			// Fetched array data become the next byte to send.
			if (st.fetch) begin
				next_st.txn = mif.rdata;
				next_st.txv = 1'b1;
			end

			// After a byte went out, prepare the following one.
			if (st.need) begin
				case (st.state)
					ST_READ: begin
						next_st.rd = 1'b1;
						next_st.maddr = st.addr;
						next_st.addr = st.addr + 15'h0001;
					end
					ST_RDSR: begin
						next_st.txn = status_byte(st.ppe, st.bp, st.wel);
						next_st.txv = 1'b1;
					end
					ST_RDID: begin
						next_st.txn = id_byte(st.id_idx); // RULE16
						next_st.txv = 1'b1;
						next_st.id_idx = (st.id_idx == ID_LAST) ? ID_LAST : st.id_idx + 2'h1;
					end
					default: begin
						next_st.txv = 1'b0;
					end
				endcase
			end

			// Each completed byte drives the command sequencer.
			if (take) begin
				case (st.state)
					ST_OP: begin
						case (b)
							OP_WREN: begin
								next_st.wel = 1'b1;
								next_st.state = ST_WRSR;
								next_st.is_read = 1'b1;
							end
							OP_WRDI: begin
								next_st.wel = 1'b0; // RULE15
								next_st.state = ST_WRSR;
								next_st.is_read = 1'b1;
							end
							OP_RDSR: begin
								next_st.txn = status_byte(st.ppe, st.bp, st.wel);
								next_st.txv = 1'b1;
								next_st.state = ST_RDSR;
							end
							OP_WRSR: begin
								next_st.state = ST_WRSR;
								next_st.is_read = 1'b0;
							end
							OP_READ: begin
								next_st.state = ST_ADDH;
								next_st.is_read = 1'b1;
							end
							OP_WRITE: begin
								next_st.state = ST_ADDH;
								next_st.is_read = 1'b0;
							end
							OP_RDID: begin
								next_st.txn = id_byte(2'h0); // RULE16
								next_st.txv = 1'b1;
								next_st.id_idx = 2'h1;
								next_st.state = ST_RDID;
							end
							default: begin
								// Unknown opcode: park in a state that ignores all later bytes.
								next_st.state = ST_WRSR; // RULE19
								next_st.is_read = 1'b1; // RULE19
							end
						endcase
					end
					ST_ADDH: begin
						next_st.addr = {b[6:0], 8'h00}; // RULE18
						next_st.state = ST_ADDL;
					end
					ST_ADDL: begin
						if (st.is_read) begin
							next_st.rd = 1'b1;
							next_st.maddr = {st.addr[14:8], b}; // RULE13
							next_st.addr = {st.addr[14:8], b} + 15'h0001;
							next_st.state = ST_READ;
						end else begin
							next_st.addr = {st.addr[14:8], b}; // RULE13
							next_st.state = ST_WRITE;
						end
					end
					ST_WRITE: begin
						// The byte is committed the cycle after it arrives; there is no busy time.
						next_st.wr = st.wel & ~blocked(st.addr, st.bp); // RULE11 RULE14 RULE15
						next_st.maddr = st.addr;
						next_st.wdata = b;
						next_st.addr = st.addr + 15'h0001;
					end
					ST_WRSR: begin
						// A set is_read marks a finished or discarded command: later bytes are ignored.
						if (!st.is_read && st.wel && !(st.ppe && !st.wp_s)) begin // RULE8 RULE15
							next_st.ppe = b[SR_PPE_BIT];
							next_st.bp = b[SR_BP_HI:SR_BP_LO]; // RULE14
						end
						next_st.is_read = 1'b1;
					end
					default: begin
						next_st.state = st.state;
					end
				endcase
			end
		end
	end

	// One register holds the whole core state; the mode and shift state survive a stopped clock.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			st <= CORE_RESET;
		end else begin
			st <= next_st; // RULE2
		end
	end
endmodule

// *** verification/smspi_sva.sv ***
// Pin-level assertions for the serial memory slave.
`timescale 1ns/1ps
module smspi_sva (
	input wire logic CLK, // Core clock.
	input wire logic NRST, // Reset, active low.
	input wire logic SCK, // Serial clock.
	input wire logic SEL_N, // Select, active low.
	input wire logic SI, // Data in.
	input wire logic PAUSE_N, // Pause, active low.
	input wire logic WP_N, // Protect pin.
	input wire logic SO, // Data out.
	input wire logic SO_OE // Output enable.
);
	logic [3:0] sf;
	logic [3:0] sp;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// Cycles since the last clock fall and since pause; both saturate so a stopped clock stays visible.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			sf <= 4'hF;
			sp <= 4'hF;
		end else begin
			sf <= (!SCK && $past(SCK)) ? 4'h0 : sf + {3'h0, sf != 4'hF};
			sp <= !PAUSE_N ? 4'h0 : sp + {3'h0, sp != 4'hF};
		end
	end
	a_oe_after_desel: assert property ($rose(SEL_N) |-> ##[1:4] !SO_OE) else $error("drive kept after deselect");
	a_oe_idle_off: assert property (SEL_N [*5] |-> !SO_OE) else $error("drive while deselected");
	a_oe_pause_off: assert property (!PAUSE_N [*4] |-> !SO_OE) else $error("drive during pause");
	a_so_fall_only: assert property (SO_OE && $past(SO_OE) && $changed(SO) |-> sf <= 4'h5)
		else $error("output moved without a fall");
	a_oe_rise_cause: assert property ($rose(SO_OE) |-> sf <= 4'h5 || sp <= 4'h6) else $error("drive began unprompted");
	a_so_clock_stop: assert property (SO_OE && $past(SO_OE) && sf > 4'h6 |-> $stable(SO)) else $error("output lost");
	a_oe_needs_sel: assert property (SO_OE |-> !$past(SEL_N, 5)) else $error("drive without select");
	a_oe_reset_exit: assert property ($rose(NRST) |-> !SO_OE) else $error("drive at reset exit");
endmodule

// *** verification/smspi_master.sv ***
// Behavioural SPI master that drives the slave pins.
`timescale 1ns/1ps
module smspi_master (
	input wire logic CLK, // Core clock.
	output logic SCK, // Serial clock.
	output logic SEL_N, // Select, active low.
	output logic SI, // Data to the slave.
	output logic PAUSE_N, // Pause, active low.
	input wire logic SO, // Data from the slave.
	input wire logic SO_OE // Slave drives SO.
);
	localparam int HALF = 10;
	logic seen_oe = 1'b0;
	initial begin
		SCK = 1'b0;
		SEL_N = 1'b1;
		SI = 1'b0;
		PAUSE_N = 1'b1;
	end
	// Outside frames the data line keeps changing so a stale level never passes for data.
	always @(posedge CLK) begin
		if (SEL_N) SI <= ~SI;
		if (SO_OE === 1'b1) seen_oe <= 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	// The clock level at select tells the slave the mode.
	task automatic sel(input bit m3);
		SCK = m3;
		w(2);
		SEL_N = 1'b0;
		w(HALF);
	endtask
	task automatic dsel;
		w(HALF);
		SEL_N = 1'b1;
		w(HALF);
	endtask
	// Shift n bits MSB first; a bit read while the slave is not driving comes back unknown.
	task automatic xb(input bit m3, input logic [7:0] t, input int n, output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			if (m3) SCK = 1'b0;
			SI = t[i];
			w(HALF);
			SCK = 1'b1;
			r[i] = (SO_OE === 1'b1) ? SO : 1'bx;
			w(HALF);
			if (!m3) SCK = 1'b0;
		end
	endtask
	// Pause moves only while the clock is low and well clear of its last fall, so that fall is not lost.
	// The clock and select wiggle inside the pause.
	task automatic pause_on;
		w(HALF);
		PAUSE_N = 1'b0;
		w(HALF);
		SCK = 1'b1;
		SEL_N = 1'b1;
		w(HALF);
		SCK = 1'b0;
		SEL_N = 1'b0;
		w(HALF);
	endtask
	task automatic pause_off;
		PAUSE_N = 1'b1;
		w(HALF);
	endtask
	task automatic noise;
		repeat (16) begin
			SCK = ~SCK;
			w(3);
		end
	endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the serial memory slave.
`timescale 1ns/1ps
module tb_top import smspi_pkg::*; ;
	typedef logic [7:0] smspi_bq_t[$];
	localparam logic [7:0] MK = 8'hA7; // Arbitrary value.
	localparam logic [7:0] DN = 8'h4E; // Arbitrary value.
	localparam logic [7:0] RV = 8'h09; // Arbitrary value.
	localparam logic [7:0] WEL = 8'h01 << SR_WEL_BIT;
	localparam logic [7:0] PPE = 8'h01 << SR_PPE_BIT;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	logic WP_N = 1'b1;
	logic SCK, SEL_N, SI, PAUSE_N, SO, SO_OE;
	logic [7:0] em [int];
	logic [1:0] bp = BP_NONE;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	always #5 CLK = ~CLK;
	smspi_slave #(.ID_MAKER(MK), .ID_DENSITY(DN), .ID_REV(RV)) smspi_slave_inst (.CLK(CLK), .NRST(NRST),
		.SCK(SCK), .SEL_N(SEL_N), .SI(SI), .PAUSE_N(PAUSE_N), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE));
	smspi_master smspi_master_inst (.CLK(CLK), .SCK(SCK), .SEL_N(SEL_N), .SI(SI), .PAUSE_N(PAUSE_N),
		.SO(SO), .SO_OE(SO_OE));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// The whole run needs about 31000 cycles; a hang is cut well past that.
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 70000) begin
			err_total++;
			stop_test();
		end
	end
	// One framed command: send the bytes, then clock in nrd answer bytes.
	task automatic run(input bit m3, input smspi_bq_t q, input int nrd, output smspi_bq_t rd);
		logic [7:0] r;
		rd = {};
		smspi_master_inst.sel(m3);
		foreach (q[i]) smspi_master_inst.xb(m3, q[i], 8, r);
		repeat (nrd) begin
			smspi_master_inst.xb(m3, 8'hFF, 8, r);
			rd.push_back(r);
		end
		smspi_master_inst.dsel();
	endtask
	function automatic bit ok(input logic [14:0] a);
		return bp == BP_NONE || (bp == BP_QUARTER && a < QUARTER_BASE) || (bp == BP_HALF && a < HALF_BASE);
	endfunction
	// Two-byte write with the ignored top address bit set; the model follows only accepted bytes.
	task automatic wr(input bit m3, input bit en, input logic [14:0] a, input logic [7:0] v0, input logic [7:0] v1);
		smspi_bq_t d;
		run(m3, '{en ? OP_WREN : OP_WRDI}, 0, d);
		run(m3, '{OP_WRITE, {1'b1, a[14:8]}, a[7:0], v0, v1}, 0, d);
		if (en && ok(a)) em[a] = v0;
		if (en && ok(15'(a + 1))) em[15'(a + 1)] = v1;
	endtask
	task automatic rdc(input bit m3, input logic [14:0] a, input int n);
		smspi_bq_t d;
		run(m3, '{OP_READ, {1'b0, a[14:8]}, a[7:0]}, n, d);
		for (int i = 0; i < n; i++) chk(d[i], em[15'(a + i)]);
	endtask
	task automatic sts(input logic [7:0] e);
		smspi_bq_t d;
		run(0, '{OP_RDSR}, 2, d);
		chk(d[0], e);
		chk(d[1], e);
	endtask
	task automatic wsr(input logic [7:0] v);
		smspi_bq_t d;
		run(0, '{OP_WREN}, 0, d);
		run(0, '{OP_WRSR, v}, 0, d);
	endtask
	// Write in one mode, read back in the other, across the wrap at the top of the array.
	task automatic t_modes;
		sts(8'h00);
		for (int m = 0; m < 2; m++) begin
			wr(m[0], 1'b1, 15'h7FFF, 8'hC3 ^ 8'(m), 8'h5A ^ 8'(m));
			rdc(!m[0], 15'h7FFF, 2);
		end
		sts(WEL);
	endtask
	// A write cut off after four data bits must leave the byte alone.
	task automatic t_abort;
		logic [7:0] r;
		logic [7:0] c [3] = '{OP_WRITE, 8'h7F, 8'hFF};
		smspi_master_inst.sel(1'b0);
		foreach (c[i]) smspi_master_inst.xb(1'b0, c[i], 8, r);
		smspi_master_inst.xb(1'b0, 8'h00, 4, r);
		smspi_master_inst.dsel();
		rdc(1'b0, 15'h7FFF, 2);
	endtask
	task automatic t_disable;
		wr(1'b0, 1'b0, 15'h7FFF, 8'h00, 8'h00);
		rdc(1'b0, 15'h7FFF, 2);
		sts(8'h00);
	endtask
	// Each protection size against the pairs that straddle its boundaries.
	task automatic t_protect;
		wr(1'b0, 1'b1, 15'h3FFF, 8'h11, 8'h22);
		wr(1'b0, 1'b1, 15'h5FFF, 8'h33, 8'h44);
		for (int b = 1; b < 4; b++) begin
			wsr(8'(b) << SR_BP_LO);
			bp = 2'(b);
			wr(1'b0, 1'b1, 15'h3FFF, 8'hA0 + 8'(b), 8'hB0 + 8'(b));
			wr(1'b0, 1'b1, 15'h5FFF, 8'hC0 + 8'(b), 8'hD0 + 8'(b));
			rdc(1'b0, 15'h3FFF, 2);
			rdc(1'b0, 15'h5FFF, 2);
			sts(WEL | (8'(b) << SR_BP_LO));
		end
		wsr(8'h00);
		bp = BP_NONE;
	endtask
	task automatic t_wp;
		wsr(PPE);
		WP_N = 1'b0;
		wsr(8'h0C);
		sts(PPE | WEL);
		WP_N = 1'b1;
		wsr(8'h00);
		sts(WEL);
	endtask
	task automatic t_id;
		smspi_bq_t d;
		logic [7:0] e [4] = '{MK, DN, RV, RV};
		run(1'b0, '{OP_RDID}, 4, d);
		foreach (d[i]) chk(d[i], e[i]);
	endtask
	// Clock noise while deselected, then an unknown opcode followed by a read request.
	task automatic t_bad;
		smspi_bq_t d;
		smspi_master_inst.seen_oe = 1'b0;
		smspi_master_inst.noise();
		run(1'b0, '{8'h00, OP_READ, 8'h7F, 8'hFF}, 1, d);
		chk(d[0], 8'hXX);
		chk({7'h00, smspi_master_inst.seen_oe}, 8'h00);
		rdc(1'b0, 15'h7FFF, 1);
	endtask
	task automatic t_pause;
		logic [7:0] r;
		logic [7:0] c [3] = '{OP_READ, 8'h3F, 8'hFF};
		smspi_master_inst.sel(1'b0);
		foreach (c[i]) smspi_master_inst.xb(1'b0, c[i], 8, r);
		smspi_master_inst.xb(1'b0, 8'hFF, 8, r);
		chk(r, em[15'h3FFF]);
		smspi_master_inst.pause_on();
		chk({7'h00, SO_OE}, 8'h00);
		smspi_master_inst.pause_off();
		smspi_master_inst.xb(1'b0, 8'hFF, 8, r);
		chk(r, em[15'h4000]);
		smspi_master_inst.dsel();
	endtask
	initial begin
		repeat (4) @(posedge CLK);
		#1 NRST = 1'b1;
		smspi_master_inst.w(3);
		t_modes();
		t_abort();
		t_disable();
		t_protect();
		t_wp();
		t_id();
		t_bad();
		t_pause();
		stop_test();
	end
endmodule
bind smspi_slave smspi_sva smspi_sva_inst (.CLK(CLK), .NRST(NRST), .SCK(SCK), .SEL_N(SEL_N), .SI(SI),
	.PAUSE_N(PAUSE_N), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE));
